// File: common/rtfc_pkg.sv
// Package for the tag feature-control block: constants, states and carriers
package rtfc_pkg;
	// ****************************************
	// Feature word layout
	// ****************************************
	localparam int FW = 16;
	localparam int B_TAMP = 0;
	localparam int B_EXT = 1;
	localparam int B_INV = 4;
	localparam int B_TRN = 5;
	localparam int B_RAW = 6;
	localparam int B_MAXBS = 9;
	localparam int B_DOUT = 10;
	localparam int B_RCUT = 11;
	localparam int B_PEPC = 13;
	localparam int B_PTID = 14;
	localparam int B_PSF = 15;
	localparam logic [15:0] FW_RST = 16'h0200;
	localparam logic [15:0] TEMP_MASK = 16'h0070;
	localparam logic [15:0] PERM_MASK = 16'hEE00;
	localparam logic [11:0] FEAT_ADDR = 12'h200;
	// ****************************************
	// Command coding and CRC
	// ****************************************
	localparam logic [15:0] OPC_TOGGLE = 16'hE007;
	localparam logic [7:0] RFU_ZERO = 8'h00;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam int CMD_BITS = 56;
	localparam int RSP_BITS = 33;
	// ****************************************
	// Register map and timing
	// ****************************************
	localparam logic [5:0] REG_FEAT = 6'h00;
	localparam logic [5:0] REG_STAT = 6'h01;
	localparam logic [5:0] REG_CTRL = 6'h02;
	localparam logic [5:0] REG_PROG = 6'h03;
	localparam logic CTRL_RST = 1'b1;
	localparam logic [15:0] PROG_RST = 16'h0400;
	localparam int CLK_MHZ = 125;
	localparam int FIELD_PULSE_NS = 1000;
	localparam int FIELD_PULSE_CYC = (FIELD_PULSE_NS * CLK_MHZ) / 1000;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [6:0] {
		TS_READY = 7'h01, TS_ARB = 7'h02, TS_REPLY = 7'h04, TS_ACK = 7'h08,
		TS_OPEN = 7'h10, TS_SECURED = 7'h20, TS_KILLED = 7'h40
	} rtfc_tag_st_t;
	typedef enum logic [2:0] {S_IDLE = 3'b001, S_PROG = 3'b010, S_RSP = 3'b100} rtfc_st_t;
	typedef struct packed {
		logic [15:0] opcode;
		logic [7:0] rfu;
		logic [15:0] data;
		logic [15:0] handle;
		logic [15:0] crc;
	} rtfc_cmd_t;
	typedef struct packed {
		logic ext_pre;
		logic hdr;
		logic [15:0] word;
		logic [15:0] handle;
		logic [15:0] crc;
	} rtfc_rsp_t;
endpackage

// File: hdl/rtfc_core.sv
// Feature-control core of a passive UHF tag: toggle command, feature word and pad behaviour
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Two backscatter levels, max by default
// [RULE2] Range-cut flag raises activation threshold
// [RULE3] Range-cut flag matchable by Select
// [RULE4] Tamper bit shows pad-link open or closed
// [RULE5] Field entry pulses the supply-sense pad
// [RULE6] Switch pad follows stored digital-output bit
// [RULE7] Digital-output bit kept nonvolatile
// [RULE8] Invert bit flips pad, not stored bit
// [RULE9] Transparent mode routes air data to pad
// [RULE10] Data form strips sync, toggles on edges
// [RULE11] Raw form passes demodulated signal through
// [RULE12] Supply-sense level mirrored in indicator bit
// [RULE13] External supply extends session flag persistence
// [RULE14] Command: opcode, RFU, masked toggles, handle, CRC
// [RULE15] Mask ones invert matching feature bits
// [RULE16] Reply: zero header, word, handle, CRC
// [RULE17] Ready/killed ignore; arbitrate states go arbitrate
// [RULE18] Open: reply unchanged word, stay open
// [RULE19] Secured: apply toggles, reply when done
// [RULE20] Zero password permits toggling without authentication
// [RULE21] Standard Write only with EPC unlocked
// [RULE22] Feature word bit layout at 200h
// [RULE23] Bad CRC, handle, sync or RFU ignored; code still moves arbitrate states to arbitrate on such commands
// [RULE24] Command CRC spans opcode through handle
// [RULE25] Successful reply uses extended preamble
// [RULE26] Power-on clears temporary bits only
module rtfc_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic cmd_vld_i,
	input wire rtfc_pkg::rtfc_cmd_t cmd_i,
	input wire logic fsync_i,
	input wire rtfc_pkg::rtfc_tag_st_t tag_st_i,
	input wire logic [15:0] handle_i,
	input wire logic [15:0] rn16_i,
	input wire logic pw_zero_i,
	input wire logic epc_locked_i,
	input wire logic wr_vld_i,
	input wire logic [11:0] wr_ptr_i,
	input wire logic [15:0] wr_data_i,
	output logic rsp_vld_o,
	output rtfc_pkg::rtfc_rsp_t rsp_o,
	output logic to_arb_o,
	input wire logic field_i,
	input wire logic demod_i,
	input wire logic env_sync_i,
	input wire logic loop_closed_i,
	input wire logic vdd_i,
	output logic vdd_o,
	output logic vdd_oe_o,
	output logic out_o,
	output logic bs_max_o,
	output logic sens_cut_o,
	output logic [15:0] sel_word_o,
	output logic s0_hold_o,
	output logic s23sl_inf_o
);
	import rtfc_pkg::*;

	// ****************************************
	// CRC helper
	// ****************************************
	function automatic logic [15:0] crc_calc(input logic [55:0] d, input int n);
		logic [15:0] c;
		logic fb;
		c = CRC_PRESET;
		for (int i = 0; i < CMD_BITS; i++) begin
			if (i < n) begin
				fb = c[15] ^ d[n - 1 - i];
				c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			end
		end
		return ~c;
	endfunction

	// ****************************************
	// State
	// ****************************************
	rtfc_st_t st_r, st_nxt;
	logic [15:0] perm_r, temp_r, pend_r, feat_r, cnt_r, prog_r, handle_r;
	logic tamp_r, ext_r, zpw_r, field_q, demod_q, tgl_r;
	logic [7:0] pls_r;
	logic ack_r, rsp_vld_r, to_arb_r, out_r, vdd_oe_r;
	logic [31:0] dat_r;
	rtfc_rsp_t rsp_r;

	// ****************************************
	// Command decode
	// ****************************************
	wire [15:0] feat_w = (perm_r & PERM_MASK) | (temp_r & TEMP_MASK)
		| {14'h0000, ext_r, tamp_r}; // RULE22
	wire hit = cmd_vld_i && (cmd_i.opcode == OPC_TOGGLE); // RULE14
	wire [15:0] crc_exp = crc_calc({cmd_i.opcode, cmd_i.rfu, cmd_i.data, cmd_i.handle}, CMD_BITS); // RULE24
	wire crc_ok = (cmd_i.crc == crc_exp);
	wire cmd_ok = crc_ok && fsync_i && (cmd_i.rfu == RFU_ZERO) && (cmd_i.handle == handle_i); // RULE23
	wire in_idle = (st_r == S_IDLE);
	wire st_ign = (tag_st_i == TS_READY) || (tag_st_i == TS_KILLED); // RULE17
	wire st_arb = (tag_st_i == TS_ARB) || (tag_st_i == TS_REPLY) || (tag_st_i == TS_ACK); // RULE17
	wire st_open = (tag_st_i == TS_OPEN);
	wire st_sec = (tag_st_i == TS_SECURED);
	// Zero password: control bit picks between free toggling and report-only
	wire tog_zero = st_open || (pw_zero_i && !zpw_r); // RULE18 RULE20 RULE23
	// Indicator and RFU positions drop out of the mask
	wire [15:0] tog = tog_zero ? 16'h0000 : ((cmd_i.data ^ rn16_i) & (PERM_MASK | TEMP_MASK)); // RULE15
	wire take = hit && in_idle && cmd_ok && (st_open || st_sec);
	wire go_prog = take && st_sec && (tog != 16'h0000); // RULE19
	wire go_rsp = take && !go_prog; // RULE18 RULE19
	wire go_arb = hit && in_idle && st_arb; // RULE17
	wire commit = (st_r == S_PROG) && (cnt_r == 16'h0000);
	wire wr_ok = wr_vld_i && !epc_locked_i && (wr_ptr_i == FEAT_ADDR); // RULE21
	wire [15:0] new_w = feat_w ^ tog; // RULE15

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		case (st_r)
			S_IDLE: st_nxt = go_prog ? S_PROG : (go_rsp ? S_RSP : S_IDLE);
			S_PROG: st_nxt = commit ? S_RSP : S_PROG;
			S_RSP: st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= S_IDLE;
			cnt_r <= 16'h0000;
			pend_r <= FW_RST;
			handle_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			if (go_prog) begin
				cnt_r <= prog_r;
				pend_r <= new_w;
			end else if (cnt_r != 16'h0000) begin
				cnt_r <= cnt_r - 16'h0001;
			end
			if (take) begin
				handle_r <= cmd_i.handle;
			end
		end
	end

	// ****************************************
	// Feature word storage
	// ****************************************
	// Permanent bits model the nonvolatile cells; only rst_i restores factory state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			perm_r <= FW_RST & PERM_MASK;
		end else if (commit) begin
			perm_r <= pend_r & PERM_MASK; // RULE7 RULE19
		end else if (wr_ok) begin
			perm_r <= wr_data_i & PERM_MASK; // RULE21
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			temp_r <= 16'h0000; // RULE26
		end else if (commit) begin
			temp_r <= pend_r & TEMP_MASK;
		end else if (wr_ok) begin
			temp_r <= wr_data_i & TEMP_MASK;
		end
	end

	// ****************************************
	// Indicator bits and supply-sense pad
	// ****************************************
	// Pad level is not sampled while the field pulse drives it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tamp_r <= 1'b0;
			ext_r <= 1'b0;
			field_q <= 1'b0;
			pls_r <= 8'h00;
			vdd_oe_r <= 1'b0;
		end else begin
			tamp_r <= !loop_closed_i; // RULE4
			if (!vdd_oe_r) begin
				ext_r <= vdd_i; // RULE12
			end
			field_q <= field_i;
			if (field_i && !field_q) begin
				pls_r <= 8'(FIELD_PULSE_CYC); // RULE5
			end else if (pls_r != 8'h00) begin
				pls_r <= pls_r - 8'h01;
			end
			vdd_oe_r <= (field_i && !field_q) || (pls_r > 8'h01); // RULE5
		end
	end

	// ****************************************
	// Switch output pad
	// ****************************************
	wire trn = feat_r[B_TRN];
	wire rise = demod_i && !demod_q && !env_sync_i;
	wire out_stat = feat_r[B_DOUT] ^ feat_r[B_INV]; // RULE6 RULE8
	wire out_trn = feat_r[B_RAW] ? demod_i : tgl_r; // RULE10 RULE11

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			demod_q <= 1'b0;
			tgl_r <= 1'b0;
			out_r <= 1'b0;
			feat_r <= FW_RST;
		end else begin
			demod_q <= demod_i;
			if (!trn) begin
				tgl_r <= 1'b0;
			end else if (rise) begin
				tgl_r <= !tgl_r; // RULE10
			end
			out_r <= trn ? out_trn : out_stat; // RULE9
			feat_r <= feat_w; // RULE3 RULE4
		end
	end

	// ****************************************
	// Reply
	// ****************************************
	wire [15:0] rsp_word = feat_w;
	wire [15:0] rsp_crc = crc_calc({23'h000000, 1'b0, rsp_word, handle_r}, RSP_BITS); // RULE16

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_vld_r <= 1'b0;
			rsp_r <= '0;
			to_arb_r <= 1'b0;
		end else begin
			rsp_vld_r <= (st_r == S_RSP);
			to_arb_r <= go_arb; // RULE17
			if (st_r == S_RSP) begin
				rsp_r.ext_pre <= 1'b1; // RULE25
				rsp_r.hdr <= 1'b0; // RULE16
				rsp_r.word <= rsp_word;
				rsp_r.handle <= handle_r;
				rsp_r.crc <= rsp_crc;
			end
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	wire req = cyc_i && stb_i && !ack_r;
	wire [5:0] ridx = adr_i[7:2];
	wire [31:0] rd_w = (ridx == REG_FEAT) ? {16'h0000, feat_r} :
		(ridx == REG_STAT) ? {24'h000000, 2'b00, tgl_r, vdd_oe_r, field_q, st_r} :
		(ridx == REG_CTRL) ? {31'h00000000, zpw_r} :
		(ridx == REG_PROG) ? {16'h0000, prog_r} : 32'h00000000;
	// Writes land on the acknowledged edge, while the master still holds the request
	wire wr_edge = cyc_i && stb_i && we_i && ack_r;
	wire wr_ctrl = wr_edge && (ridx == REG_CTRL) && sel_i[0];
	wire wr_prog = wr_edge && (ridx == REG_PROG);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			zpw_r <= CTRL_RST;
			prog_r <= PROG_RST;
		end else begin
			ack_r <= req;
			if (req && !we_i) begin
				dat_r <= rd_w;
			end
			if (wr_ctrl) begin
				zpw_r <= dat_i[0];
			end
			if (wr_prog && sel_i[0]) begin
				prog_r[7:0] <= dat_i[7:0];
			end
			if (wr_prog && sel_i[1]) begin
				prog_r[15:8] <= dat_i[15:8];
			end
		end
	end

	// ****************************************
	// Output drive
	// ****************************************
	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign rsp_vld_o = rsp_vld_r;
	assign rsp_o = rsp_r;
	assign to_arb_o = to_arb_r;
	assign vdd_o = vdd_oe_r;
	assign vdd_oe_o = vdd_oe_r;
	assign out_o = out_r;
	assign bs_max_o = feat_r[B_MAXBS]; // RULE1
	assign sens_cut_o = feat_r[B_RCUT]; // RULE2
	assign sel_word_o = feat_r; // RULE3
	assign s0_hold_o = feat_r[B_EXT]; // RULE13
	assign s23sl_inf_o = feat_r[B_EXT]; // RULE13

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_open_cmd;
		take && st_open;
	endsequence
	sequence s_reply_unchanged;
		##2 rsp_vld_r && (rsp_r.word == $past(feat_w, 2));
	endsequence

	a_open_unchanged: assert property (s_open_cmd |-> s_reply_unchanged) // RULE18
		else $error("open state reply word changed");
	a_reply_preamble: assert property (rsp_vld_r |-> rsp_r.ext_pre && !rsp_r.hdr) // RULE25
		else $error("reply without extended preamble or zero header");
	a_arb_silent: assert property (go_arb |=> to_arb_r ##1 !rsp_vld_r) // RULE17
		else $error("arbitrate path replied or missed state move");
	a_ready_ignore: assert property (hit && st_ign |=> !to_arb_r && st_r == S_IDLE) // RULE17
		else $error("command acted on in ready or killed");
	a_bad_ignore: assert property (hit && !cmd_ok |=> st_r == S_IDLE) // RULE23
		else $error("invalid command was taken");
	a_sec_prog: assert property (go_prog |=> st_r == S_PROG && pend_r == $past(new_w)) // RULE19
		else $error("secured toggle not scheduled");
	a_por_temp: assert property (por_i |=> (temp_r & TEMP_MASK) == 16'h0000 && perm_r == $past(perm_r)) // RULE26
		else $error("power-on did not clear only temporary bits");
	a_field_pulse: assert property ($rose(field_i) |=> vdd_oe_o && vdd_o) // RULE5
		else $error("no supply-sense pulse on field entry");
	a_static_out: assert property (!trn && !$past(trn) |=> out_o == $past(out_stat)) // RULE6 RULE8
		else $error("switch pad does not follow stored level");
	a_raw_pass: assert property (trn && feat_r[B_RAW] |=> out_o == $past(demod_i)) // RULE11
		else $error("raw form does not pass demodulated signal");
	a_locked_write: assert property (wr_vld_i && epc_locked_i && !commit && !por_i |=> perm_r == $past(perm_r)) // RULE21
		else $error("write accepted with locked bank");

	// ****************************************
	// Checks on replies, storage and pads
	// ****************************************
	// Reply word is held against the staged value, not the live word it was built from
	sequence s_commit_step;
		st_r == S_RSP ##1 rsp_vld_r && ((rsp_r.word & (PERM_MASK | TEMP_MASK)) ==
			($past(pend_r, 2) & (PERM_MASK | TEMP_MASK)));
	endsequence

	a_commit_reply: assert property (commit |=> s_commit_step) // RULE19
		else $error("committed toggle not reported");
	a_quick_reply: assert property (go_rsp |-> ##2 rsp_vld_r) // RULE19
		else $error("unchanged word not replied at once");
	a_open_keep: assert property (take && st_open && !wr_ok && !por_i |=> perm_r == $past(perm_r) && temp_r == $past(temp_r)) // RULE18
		else $error("open state altered the feature word");
	a_write_open: assert property (wr_ok && !commit |=> perm_r == ($past(wr_data_i) & PERM_MASK)) // RULE21
		else $error("write with unlocked bank not stored");
	a_tamper_bit: assert property (!loop_closed_i |-> ##2 sel_word_o[B_TAMP]) // RULE4
		else $error("open pad link not flagged");
	a_ext_mirror: assert property (!vdd_oe_r && vdd_i |-> ##2 sel_word_o[B_EXT] && s0_hold_o) // RULE12 RULE13
		else $error("supply-sense level not mirrored");
	a_pulse_end: assert property (pls_r == 8'h01 && !(field_i && !field_q) |=> !vdd_oe_o) // RULE5
		else $error("supply-sense pulse too long");
	a_data_toggle: assert property (trn && rise |=> tgl_r == !$past(tgl_r)) // RULE10
		else $error("data form missed a rising edge");
	a_sync_strip: assert property (trn && env_sync_i |=> tgl_r == $past(tgl_r)) // RULE10
		else $error("frame sync edge reached the pad");
	a_tgl_clear: assert property (!trn |=> !tgl_r) // RULE10
		else $error("data form does not start from low");
	a_trn_route: assert property (trn && !feat_r[B_RAW] |=> out_o == $past(tgl_r)) // RULE9
		else $error("transparent data not routed to pad");
endmodule

// File: tb/rtfc_reader_model.sv
// Interrogator model: frames toggle commands and drives the field envelope
`timescale 1ns/1ps
module rtfc_reader_model (
	input wire logic clk_i,
	input wire logic [15:0] rn16_i,
	output logic cmd_vld_o,
	output rtfc_pkg::rtfc_cmd_t cmd_o,
	output logic fsync_o,
	output logic field_o,
	output logic demod_o,
	output logic env_sync_o
);
	import rtfc_pkg::*;
	// ****
	// Air side
	// ****
	initial begin
		cmd_vld_o = 1'h0;
		cmd_o = '0;
		fsync_o = 1'h0;
		field_o = 1'h0;
		demod_o = 1'h0;
		env_sync_o = 1'h0;
	end
	// CRC-16 sent MSB first, preset all ones, complemented
	function automatic logic [15:0] crc16(input logic [55:0] v, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = n - 1; i >= 0; i--) begin
			c = {c[14:0], 1'h0} ^ (((c[15] ^ v[i]) == 1'h1) ? 16'h1021 : 16'h0000);
		end
		return ~c;
	endfunction
	task automatic send(input logic [15:0] op, input logic [15:0] mask, input logic [7:0] rfu,
		input logic [15:0] hdl, input logic bad, input logic sync);
		logic [55:0] body;
		body = {op, rfu, mask ^ rn16_i, hdl};
		@(posedge clk_i);
		cmd_vld_o <= 1'h1;
		fsync_o <= sync;
		cmd_o <= {body, crc16(body, 56) ^ {15'h0000, bad}};
		@(posedge clk_i);
		cmd_vld_o <= 1'h0;
		fsync_o <= 1'h0;
		cmd_o <= ~cmd_o; // No stale frame once released
	endtask
	task automatic air(input logic f, input logic d, input logic s);
		@(posedge clk_i);
		field_o <= f;
		demod_o <= d;
		env_sync_o <= s;
	endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the tag feature-control core
`timescale 1ns/1ps
module testbench;
	import rtfc_pkg::*;
	logic clk_i, rst_i, por_i, we_i, cyc_i, stb_i, ack_o, rsp_vld_o, to_arb_o, cmd_vld_i, fsync_i;
	logic field_i, demod_i, env_sync_i, pw_zero_i, epc_locked_i, wr_vld_i, loop_closed_i, vdd_ext;
	logic vdd_o, vdd_oe_o, out_o, bs_max_o, sens_cut_o, s0_hold_o, s23sl_inf_o;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i;
	logic [11:0] wr_ptr_i;
	logic [15:0] handle_i, rn16_i, wr_data_i, sel_word_o, exp_w;
	rtfc_tag_st_t tag_st_i;
	rtfc_cmd_t cmd_i;
	rtfc_rsp_t rsp_o;
	wire logic vdd_pad;
	int num_errors, checks_done;
	logic zp_ok;
	// Pad level from both drivers
	assign vdd_pad = vdd_oe_o ? vdd_o : vdd_ext;
	rtfc_core u_dut (.clk_i, .rst_i, .por_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
		.cmd_vld_i, .cmd_i, .fsync_i, .tag_st_i, .handle_i, .rn16_i, .pw_zero_i, .epc_locked_i, .wr_vld_i,
		.wr_ptr_i, .wr_data_i, .rsp_vld_o, .rsp_o, .to_arb_o, .field_i, .demod_i, .env_sync_i, .loop_closed_i,
		.vdd_i(vdd_pad), .vdd_o, .vdd_oe_o, .out_o, .bs_max_o, .sens_cut_o, .sel_word_o, .s0_hold_o, .s23sl_inf_o);
	rtfc_reader_model u_rdr (.clk_i, .rn16_i, .cmd_vld_o(cmd_vld_i), .cmd_o(cmd_i), .fsync_o(fsync_i),
		.field_o(field_i), .demod_o(demod_i), .env_sync_o(env_sync_i));
	// ****
	// Shared tasks
	// ****
	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic results();
		$display("Checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 50);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		if (ack_o !== 1'h1) begin
			num_errors++;
			results();
		end
	endtask
	task automatic wait_rsp(input int lim, output logic got);
		got = 1'h0;
		for (int i = 0; i < lim && got !== 1'h1; i++) begin
			@(posedge clk_i);
			got = (rsp_vld_o === 1'h1);
		end
	endtask
	task automatic tog(input logic [15:0] m);
		logic got;
		if (tag_st_i == TS_SECURED && zp_ok) begin
			exp_w = exp_w ^ (m & (TEMP_MASK | PERM_MASK));
		end
		u_rdr.send(OPC_TOGGLE, m, RFU_ZERO, handle_i, 1'h0, 1'h1);
		wait_rsp(40, got);
		if (got !== 1'h1) begin
			num_errors++;
			results();
		end
		check(rsp_o, {2'h2, exp_w, handle_i, u_rdr.crc16({24'h0, exp_w, handle_i}, 33)});
		repeat (4) @(posedge clk_i);
		check(sel_word_o, exp_w);
	endtask
	task automatic quiet(input logic [7:0] rfu, input logic [15:0] h, input logic bad, input logic sync);
		logic got;
		u_rdr.send(OPC_TOGGLE, 16'h0800, rfu, h, bad, sync);
		wait_rsp(20, got);
		check(got, 1'h0);
		check(sel_word_o, exp_w);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		logic [31:0] q;
		check(sel_word_o, 16'h0200);
		check(bs_max_o, 1'h1);
		check(out_o, 1'h0);
		wb(1'h0, 8'h00, 32'h0, q);
		check(q, 32'h0200);
		wb(1'h0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		wb(1'h0, 8'h08, 32'h0, q);
		check(q, 32'h1);
		wb(1'h1, 8'h0C, 32'h4, q);
		wb(1'h0, 8'h0C, 32'h0, q);
		check(q, 32'h4);
		$display("Test reset done");
	endtask
	task automatic t_secure();
		logic [31:0] q;
		logic got;
		tag_st_i <= TS_OPEN;
		@(posedge clk_i);
		tog(16'h0800);
		tag_st_i <= TS_SECURED;
		@(posedge clk_i);
		tog(16'h0800);
		check(sens_cut_o, 1'h1);
		tog(16'h0800);
		check(sens_cut_o, 1'h0);
		tog(16'h0400);
		check(out_o, 1'h1);
		tog(16'h0010);
		check({out_o, sel_word_o[B_DOUT]}, 2'h1);
		@(posedge clk_i);
		por_i <= 1'h1;
		@(posedge clk_i);
		por_i <= 1'h0;
		exp_w = exp_w & ~TEMP_MASK;
		repeat (4) @(posedge clk_i);
		check(sel_word_o, exp_w);
		check(out_o, 1'h1);
		tog(16'h0200);
		check(bs_max_o, 1'h0);
		tog(16'h0000);
		u_rdr.send(OPC_TOGGLE, 16'h0000, RFU_ZERO, handle_i, 1'h0, 1'h1);
		wait_rsp(2, got);
		check(got, 1'h1);
		pw_zero_i <= 1'h1;
		tog(16'h8000);
		wb(1'h1, 8'h08, 32'h0, q);
		zp_ok = 1'h0;
		tog(16'h8000);
		pw_zero_i <= 1'h0;
		zp_ok = 1'h1;
		$display("Test toggle done");
	endtask
	task automatic t_refuse();
		rtfc_tag_st_t sts[3] = '{TS_ARB, TS_REPLY, TS_ACK};
		logic seen;
		logic got;
		quiet(RFU_ZERO, handle_i, 1'h1, 1'h1);
		quiet(RFU_ZERO, 16'h1235, 1'h0, 1'h1);
		quiet(RFU_ZERO, handle_i, 1'h0, 1'h0);
		quiet(8'h01, handle_i, 1'h0, 1'h1);
		tag_st_i <= TS_READY;
		quiet(RFU_ZERO, handle_i, 1'h0, 1'h1);
		tag_st_i <= TS_KILLED;
		quiet(RFU_ZERO, handle_i, 1'h0, 1'h1);
		foreach (sts[k]) begin
			tag_st_i <= sts[k];
			u_rdr.send(OPC_TOGGLE, 16'h0800, RFU_ZERO, handle_i, 1'h0, 1'h1);
			seen = 1'h0;
			for (int i = 0; i < 4; i++) begin
				@(posedge clk_i);
				seen = seen | (to_arb_o === 1'h1);
			end
			wait_rsp(10, got);
			check({seen, got}, 2'h2);
		end
		tag_st_i <= TS_SECURED;
		$display("Test refusal done");
	endtask
	task automatic t_pads();
		int n;
		logic o0;
		n = 0;
		u_rdr.air(1'h1, 1'h0, 1'h0);
		for (int i = 0; i < 4 && vdd_oe_o !== 1'h1; i++) @(posedge clk_i);
		check({vdd_oe_o, vdd_o}, 2'h3);
		while (vdd_oe_o === 1'h1 && n < 300) begin
			n++;
			@(posedge clk_i);
		end
		check(n, FIELD_PULSE_CYC);
		loop_closed_i <= 1'h0;
		vdd_ext <= 1'h1;
		repeat (4) @(posedge clk_i);
		check(sel_word_o, exp_w | 16'h0003);
		check({s0_hold_o, s23sl_inf_o}, 2'h3);
		loop_closed_i <= 1'h1;
		vdd_ext <= 1'h0;
		repeat (4) @(posedge clk_i);
		tog(16'h0020);
		o0 = out_o;
		u_rdr.air(1'h1, 1'h1, 1'h0);
		repeat (4) @(posedge clk_i);
		check(out_o, !o0);
		u_rdr.air(1'h1, 1'h0, 1'h1);
		u_rdr.air(1'h1, 1'h1, 1'h1);
		repeat (4) @(posedge clk_i);
		check(out_o, !o0);
		u_rdr.air(1'h1, 1'h0, 1'h0);
		tog(16'h0040);
		u_rdr.air(1'h1, 1'h1, 1'h0);
		repeat (3) @(posedge clk_i);
		check(out_o, 1'h1);
		u_rdr.air(1'h1, 1'h0, 1'h0);
		repeat (3) @(posedge clk_i);
		check(out_o, 1'h0);
		tog(16'h0060);
		$display("Test pads done");
	endtask
	task automatic t_write(input logic lock, input logic [15:0] d);
		@(posedge clk_i);
		epc_locked_i <= lock;
		wr_vld_i <= 1'h1;
		wr_ptr_i <= FEAT_ADDR;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_vld_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		exp_w = lock ? exp_w : d;
		check(sel_word_o, exp_w);
		$display("Test write done");
	endtask
	initial begin
		{por_i, we_i, cyc_i, stb_i, pw_zero_i, epc_locked_i, wr_vld_i, vdd_ext} = 8'h00;
		{adr_i, dat_i, wr_ptr_i, wr_data_i} = '0;
		rst_i = 1'h1;
		sel_i = 4'hF;
		loop_closed_i = 1'h1;
		tag_st_i = TS_READY;
		handle_i = 16'h1234;
		rn16_i = 16'hA5C3;
		exp_w = 16'h0200;
		zp_ok = 1'h1;
		num_errors = 0;
		checks_done = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		t_reset();
		t_secure();
		t_refuse();
		t_pads();
		t_write(1'h1, 16'h8A00);
		t_write(1'h0, 16'h8A00);
		results();
	end
endmodule
